// ===== bench/smer_asserts.sv
// Purpose: port-level checks of stop entry and release
// Assumes: one clock domain, clk_en held high by the bench
// Notes:   sees only top ports; sync delays bounded loosely
`timescale 1ns/100ps
module smer_asserts (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        stop_pin_n,
    input  wire logic        key_wakeup,
    input  wire logic        key_level,
    input  wire logic        volt_detect,
    input  wire logic        high_osc_en,
    input  wire logic        low_osc_en,
    input  wire logic        core_run,
    input  wire logic        tg_clear,
    input  wire logic        pin_sync,
    input  wire logic [15:0] resume_pc
);
    // ------------------------------------------------------------
    // helpers and properties
    // ------------------------------------------------------------
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire  osc_off = !high_osc_en && !low_osc_en;  // both oscillators held
    logic was_off;                                // set while stopped
    // was_off tells a stop release apart from the reset warm-up
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            was_off <= 1'b0;
        end else if (osc_off) begin
            was_off <= 1'b1;
        end else if (core_run) begin
            was_off <= 1'b0;
        end
    end
    property p_osc_off; $fell(core_run) |-> osc_off; endproperty
    a_osc_off: assert property (p_osc_off) else $error("osc running at entry");
    property p_core_halt; osc_off |-> !core_run; endproperty
    a_core_halt: assert property (p_core_halt) else $error("core runs while stopped");
    property p_tg_entry; $fell(core_run) |-> tg_clear; endproperty
    a_tg_entry: assert property (p_tg_entry) else $error("no clear at entry");
    property p_tg_resume; $rose(core_run) && was_off |-> tg_clear; endproperty
    a_tg_resume: assert property (p_tg_resume) else $error("no clear at resume");
    property p_warm; osc_off ##1 !osc_off |-> !core_run; endproperty
    a_warm: assert property (p_warm) else $error("core runs in warm-up");
    property p_pc_hold; !core_run [*3] |-> $stable(resume_pc); endproperty
    a_pc_hold: assert property (p_pc_hold) else $error("held pc moved");
    property p_pin; $rose(stop_pin_n) |-> ##[1:3] pin_sync; endproperty
    a_pin: assert property (p_pin) else $error("pin not seen");
    property p_pin_rel; osc_off [*6] ##1 $rose(pin_sync) |-> ##[0:3] !osc_off; endproperty
    a_pin_rel: assert property (p_pin_rel) else $error("pin release missed");
    property p_aux_rel;
        osc_off [*6] ##1 (volt_detect || key_wakeup == key_level) |-> ##[0:5] !osc_off;
    endproperty
    a_aux_rel: assert property (p_aux_rel) else $error("key or volt release missed");
    c_entry: cover property ($fell(core_run));
    c_resume: cover property ($rose(core_run) && was_off);
    c_volt: cover property (osc_off ##1 volt_detect);
endmodule
bind smer_top smer_asserts smer_asserts_inst (
    .hclk(hclk), .hresetn(hresetn), .stop_pin_n(stop_pin_n), .key_wakeup(key_wakeup),
    .key_level(key_level), .volt_detect(volt_detect), .high_osc_en(high_osc_en),
    .low_osc_en(low_osc_en), .core_run(core_run), .tg_clear(tg_clear),
    .pin_sync(pin_sync), .resume_pc(resume_pc));

// ===== bench/smer_wake_src.sv
// Purpose: external wake source on the release pin
// Assumes: bench asks for release with wake_req
// Notes:   answers wake_dly + 1 cycles after wake_req, pin idles low
`timescale 1ns/100ps
module smer_wake_src (
    input  wire logic       hclk,
    input  wire logic       wake_req,   // release wanted
    input  wire logic [3:0] wake_dly,   // prompt or slow answer
    output logic            stop_pin_n
);
    logic [3:0] cnt = 4'h0;             // delay count
    initial stop_pin_n = 1'b0;
    // pin high is the release level, low keeps the block stopped
    always @(posedge hclk) begin
        if (!wake_req) begin
            cnt        <= 4'h0;
            stop_pin_n <= 1'b0;
        end else if (cnt == wake_dly) begin
            stop_pin_n <= 1'b1;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule

// ===== bench/tb_stop_mode_entry_release.sv
// Purpose: self-checking bench for stop entry and release
// Assumes: hready looped from hreadyout, clk_en held high
// Notes:   xorshift stimulus from seed 81
`timescale 1ns/100ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin error_cnt++; \
    $display("ERROR %s expected %h seen %h", n, e, s); end end
module tb_stop_mode_entry_release import smer_pkg::*;;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;       // async, active low
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [15:0] cpu_pc = 16'h0;
    logic        instr_done = 1'b0;
    logic        key_wakeup = 1'b0;    // away from release level
    logic        key_level = 1'b1;
    logic        volt_detect = 1'b0;
    logic        wake_req = 1'b0;      // partner control
    logic [3:0]  wake_dly = 4'h0;
    logic [31:0] hrdata, seed = 32'd81;
    logic        hreadyout, hresp, stop_pin_n, high_osc_en, low_osc_en, core_run;
    logic        tg_clear, port_drive, warm_from_low, pin_sync;
    logic [15:0] resume_pc;
    int          error_cnt = 0;
    int          compares = 0;
    smer_top smer_top_inst (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .cpu_pc(cpu_pc), .instr_done(instr_done), .stop_pin_n(stop_pin_n),
        .key_wakeup(key_wakeup), .key_level(key_level), .volt_detect(volt_detect),
        .high_osc_en(high_osc_en), .low_osc_en(low_osc_en), .core_run(core_run),
        .tg_clear(tg_clear), .port_drive(port_drive), .warm_from_low(warm_from_low),
        .pin_sync(pin_sync), .resume_pc(resume_pc));
    smer_wake_src smer_wake_src_inst (.hclk(hclk), .wake_req(wake_req),
        .wake_dly(wake_dly), .stop_pin_n(stop_pin_n));
    always #5 hclk = ~hclk;
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // single word transfer; entered just after a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    // request stop; pin set raises the pin edge in the blind cycle
    task automatic stop_req(input logic [7:0] c, input logic pin);
        logic [31:0] r;
        bus(1'b1, SMER_SYSCTL_OFFSET, {24'h0, c}, r);
        instr_done <= 1'b1;
        if (pin) wake_req <= 1'b1;
        @(posedge hclk);
        instr_done <= 1'b0;
    endtask
    // bounded wait; returns at a falling edge so outputs are settled
    task automatic wait_run(output int n);
        n = 0;
        do begin
            @(negedge hclk);
            n++;
        end while (core_run !== 1'b1 && n < 500);
    endtask
    task automatic wrap_up();
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        logic [31:0] r, v;
        logic [7:0]  c;
        int          n;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        wait_run(n);
        @(posedge hclk);
        bus(1'b0, SMER_STATUS_OFFSET, 32'h0, r);
        `CHK("state", SMER_RUN, r[4:1])
        bus(1'b0, SMER_WARMUP_OFFSET, 32'h0, r);
        `CHK("warmup", SMER_WARMUP_RESET, r[15:0])
        bus(1'b1, 8'h10, 32'hFFFFFFFF, r);
        bus(1'b0, 8'h10, 32'h0, r);
        `CHK("unmapped", 32'h0, r)
        wake_req <= 1'b1;
        repeat (6) @(posedge hclk);
        stop_req(8'hC0, 1'b0);
        repeat (3) @(posedge hclk);
        bus(1'b0, SMER_SYSCTL_OFFSET, 32'h0, r);
        `CHK("stop_bit", 1'b0, r[7])
        bus(1'b0, SMER_STATUS_OFFSET, 32'h0, r);
        `CHK("state", SMER_RUN, r[4:1])
        $display("test refuse done");
        // modes and clock sources; edge mode enters with the pin high
        for (int i = 0; i < 8; i++) begin
            v = rnd();
            c = {1'b1, i[0], 1'b0, v[0], 2'b00, i[1], ~i[1]};
            cpu_pc   <= v[31:16];
            wake_req <= ~i[0];
            bus(1'b1, SMER_WARMUP_OFFSET, {28'h0, v[11:8]} + 32'h8, r);
            repeat (4) @(posedge hclk);
            bus(1'b0, SMER_STATUS_OFFSET, 32'h0, r);
            `CHK("pin", ~i[0], r[0])
            stop_req(c, 1'b0);
            repeat (3) @(negedge hclk);
            `CHK("osc", 2'b00, {high_osc_en, low_osc_en})
            `CHK("port", v[0], port_drive)
            `CHK("pc", v[31:16] + 16'(2 * SMER_INSTR_BYTES), resume_pc)
            @(posedge hclk);
            wake_req <= 1'b0;
            repeat (6) @(posedge hclk);
            bus(1'b0, SMER_STATUS_OFFSET, 32'h0, r);
            `CHK("state", SMER_STOP, r[4:1])
            wake_dly <= v[15:12];
            wake_req <= 1'b1;
            wait_run(n);
            `CHK("warm_len", 1'b1, n > v[11:8] + 8)
            `CHK("warm_src", i[1], warm_from_low)
            @(posedge hclk);
            bus(1'b0, SMER_STATUS_OFFSET, 32'h0, r);
            `CHK("state", SMER_RUN, r[4:1])
            $display("test mode %0d done", i);
        end
        wake_req <= 1'b0;
        wake_dly <= 4'h0;
        repeat (4) @(posedge hclk);
        stop_req(8'h80, 1'b1);
        repeat (8) @(posedge hclk);
        bus(1'b0, SMER_STATUS_OFFSET, 32'h0, r);
        `CHK("state", SMER_STOP, r[4:1])
        key_wakeup <= key_level;
        wait_run(n);
        `CHK("key_rel", 1'b1, core_run)
        @(posedge hclk);
        key_wakeup <= ~key_level;
        stop_req(8'h80, 1'b0);
        repeat (8) @(posedge hclk);
        volt_detect <= 1'b1;
        wait_run(n);
        `CHK("volt_rel", 1'b1, core_run)
        @(posedge hclk);
        volt_detect <= 1'b0;
        stop_req(8'h80, 1'b0);
        repeat (8) @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        wait_run(n);
        `CHK("rst_rel", 1'b1, core_run)
        @(posedge hclk);
        bus(1'b0, SMER_SYSCTL_OFFSET, 32'h0, r);
        `CHK("ctl", SMER_SYSCTL_RESET, r[7:0])
        $display("test release sources done");
        wrap_up();
    end
    // hang guard, well beyond the several hundred cycles needed
    initial begin
        #300000;
        error_cnt++;
        wrap_up();
    end
endmodule

// ===== common/smer_pkg.sv
// Purpose: shared constants for the stop mode entry and release block
// Assumes: 32-bit AHB-Lite register bus, 100 MHz hclk
// Notes:   offsets are byte addresses of aligned words
package smer_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] SMER_SYSCTL_OFFSET  = 8'h00; // system_control_one
    localparam logic [7:0] SMER_WARMUP_OFFSET  = 8'h04; // warmup_count_setting
    localparam logic [7:0] SMER_STATUS_OFFSET  = 8'h08; // live state
    localparam logic [7:0] SMER_PCSAVE_OFFSET  = 8'h0C; // held program counter
    // ------------------------------------------------------------
    // field positions of system_control_one
    // ------------------------------------------------------------
    localparam int SMER_STOP_BIT    = 7;  // stop request
    localparam int SMER_RELEASE_MODE_SELECT_BIT    = 6;  // release_mode_select
    localparam int SMER_PORT_OUTPUT_ENABLE_BIT   = 4;  // port_output_enable
    localparam int SMER_WSEL_BIT    = 0;  // warmup_source_select
    localparam int SMER_LOWCLK_BIT  = 1;  // main clock from low_freq_clock
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  SMER_SYSCTL_RESET = 8'h00;
    localparam logic [15:0] SMER_WARMUP_RESET = 16'h0010;
    localparam logic [15:0] SMER_PC_RESET     = 16'h0000;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int SMER_CLK_NS        = 10;  // hclk period
    localparam int SMER_MACHINE_NS    = 10;  // one machine cycle, ns
    localparam int SMER_BLIND_CYCLES  =
        (SMER_MACHINE_NS + SMER_CLK_NS - 1) / SMER_CLK_NS; // round up
    localparam int SMER_RST_WARMUP    = 16;  // warm-up cycles after reset
    localparam int SMER_SYNC_STAGES   = 2;   // pin synchroniser depth
    localparam int SMER_INSTR_BYTES   = 1;   // pc step per instruction
    // ------------------------------------------------------------
    // state encoding, one-hot
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        SMER_RUN    = 4'b0001,
        SMER_BLIND  = 4'b0010,
        SMER_STOP   = 4'b0100,
        SMER_WARM   = 4'b1000
    } smer_state_type;
endpackage

// ===== src/smer_top.sv
// Purpose: stop mode entry, hold and release for a small controller
// Assumes: cpu writes system_control_one over AHB-Lite; release pin async
// Notes:   oscillators and core are gated by registered enables
`timescale 1ns/100ps
module smer_top
    import smer_pkg::*;
#(
    parameter int WARM_W = 16               // warm-up counter width
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        clk_en,         // freezes all state when low
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // cpu side
    input  wire logic [15:0] cpu_pc,         // address of requesting instruction
    input  wire logic        instr_done,     // requesting instruction completed
    // wake sources, asynchronous
    input  wire logic        stop_pin_n,     // shared_port_bit / interrupt five
    input  wire logic        key_wakeup,
    input  wire logic        key_level,      // release level of key wakeup
    input  wire logic        volt_detect,
    // controls to the rest of the chip
    output logic             high_osc_en,
    output logic             low_osc_en,
    output logic             core_run,
    output logic             tg_clear,       // timing generator clear pulse
    output logic             port_drive,     // port latches driven during stop
    output logic             warm_from_low,  // warm-up source for this release
    output logic             pin_sync,       // synced pin for port/interrupt
    output logic      [15:0] resume_pc
);
    // ------------------------------------------------------------
    // state record
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0]        pin_s;      // pin synchroniser
        logic [1:0]        key_s;      // key synchroniser
        logic [1:0]        vd_s;       // voltage detect synchroniser
        logic              pin_prev;   // for edge detection
        logic [7:0]        sysctl;     // system_control_one
        logic [15:0]       warm_set;   // warmup_count_setting
        smer_state_type    st;
        logic [WARM_W-1:0] cnt;        // warm-up / blind counter
        logic              release_mode_select_held;  // mode latched at entry
        logic              low_held;   // clock source latched at entry
        logic              pend;       // stop requested, waiting instr
        logic              wr_pend;    // ahb write data phase
        logic              rd_pend;    // ahb read data phase
        logic [7:0]        addr_q;     // latched address
        logic [15:0]       pc_q;
        logic [31:0]       rdata;
        logic              hi_en;
        logic              lo_en;
        logic              run;
        logic              tgc;
        logic              pdrv;
        logic              wlow;
    } smer_regs_type;

    smer_regs_type r;       // current state
    smer_regs_type next_r;  // next state

    // reset value of the whole record; warm-up after reset is counted
    localparam smer_regs_type SMER_RESET = '{
        pin_s: 2'h0, key_s: 2'h0, vd_s: 2'h0, pin_prev: 1'b0,
        sysctl: SMER_SYSCTL_RESET, warm_set: SMER_WARMUP_RESET,
        st: SMER_WARM, cnt: WARM_W'(SMER_RST_WARMUP),
        release_mode_select_held: 1'b0, low_held: 1'b0, pend: 1'b0,
        wr_pend: 1'b0, rd_pend: 1'b0, addr_q: 8'h00,
        pc_q: SMER_PC_RESET, rdata: 32'h0000_0000,
        hi_en: 1'b1, lo_en: 1'b0, run: 1'b0, tgc: 1'b1,
        pdrv: 1'b1, wlow: 1'b0
    };

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    logic pin_hi;      // synced pin level
    logic pin_rise;    // synced rising edge
    logic key_hit;     // key wakeup at its release level
    logic wake_any;    // any non-pin release source
    logic ahb_go;      // valid address phase

    always_comb begin
        next_r   = r;
        pin_hi   = r.pin_s[1];
        pin_rise = r.pin_s[1] & ~r.pin_prev;
        key_hit  = (r.key_s[1] == key_level);
        wake_any = key_hit | r.vd_s[1];
        ahb_go   = hsel & hready & htrans[1];

        // synchronisers: only the second stage is read by logic
        next_r.pin_s    = {r.pin_s[0], stop_pin_n};    // pin high means release
        next_r.key_s    = {r.key_s[0], key_wakeup};
        next_r.vd_s     = {r.vd_s[0], volt_detect};
        next_r.pin_prev = r.pin_s[1];
        next_r.tgc      = 1'b0;

        // bus: address phase latches, data phase acts
        next_r.wr_pend = ahb_go & hwrite;
        next_r.rd_pend = ahb_go & ~hwrite;
        if (ahb_go) begin
            next_r.addr_q = haddr[7:0];
        end
        if (r.wr_pend) begin
            // writes land in the data phase
            unique case (r.addr_q)
                SMER_SYSCTL_OFFSET: begin
                    next_r.sysctl = hwdata[7:0];
                    if (hwdata[SMER_STOP_BIT]) begin
                        next_r.pend = 1'b1;
                    end
                end
                SMER_WARMUP_OFFSET: next_r.warm_set = hwdata[15:0];
                default: ;                                         // ignored
            endcase
        end
        if (ahb_go & ~hwrite) begin
            unique case (haddr[7:0])
                SMER_SYSCTL_OFFSET: next_r.rdata = {24'h0, r.sysctl};
                SMER_WARMUP_OFFSET: next_r.rdata = {16'h0, r.warm_set};
                SMER_STATUS_OFFSET: next_r.rdata = {27'h0, r.st, pin_hi};
                SMER_PCSAVE_OFFSET: next_r.rdata = {16'h0, r.pc_q};
                default:            next_r.rdata = 32'h0000_0000;
            endcase
        end

        unique case (r.st)
            SMER_RUN: begin
                // request only acts once its instruction has finished
                if (r.pend & instr_done) begin
                    next_r.pend = 1'b0;
                    next_r.sysctl[SMER_STOP_BIT] = 1'b0;
                    // level mode with the pin already high: keep running
                    if (r.sysctl[SMER_RELEASE_MODE_SELECT_BIT] & pin_hi) begin
                        next_r.st = SMER_RUN;
                    end else begin
                        // edge mode enters regardless of pin
                        next_r.release_mode_select_held = r.sysctl[SMER_RELEASE_MODE_SELECT_BIT];
                        next_r.low_held  = r.sysctl[SMER_LOWCLK_BIT];
                        next_r.pc_q = cpu_pc + 16'(2 * SMER_INSTR_BYTES);
                        // blind span covers the synchroniser lag as well, so a
                        // pin edge inside the first machine cycle is not seen
                        next_r.cnt  = WARM_W'(SMER_BLIND_CYCLES + SMER_SYNC_STAGES);
                        next_r.st   = SMER_BLIND;
                        next_r.run  = 1'b0;
                        next_r.hi_en = 1'b0;
                        next_r.lo_en = 1'b0;
                        next_r.tgc  = 1'b1;
                        next_r.pdrv = r.sysctl[SMER_PORT_OUTPUT_ENABLE_BIT];
                    end
                end
            end
            SMER_BLIND: begin
                // edges in the first machine cycle are not release events
                next_r.cnt = r.cnt - WARM_W'(1);
                if (r.cnt == WARM_W'(1)) begin
                    next_r.st = SMER_STOP;
                end
            end
            SMER_STOP: begin
                if ((r.release_mode_select_held & pin_hi) |
                    (~r.release_mode_select_held & pin_rise) |
                    wake_any) begin
                    next_r.st    = SMER_WARM;
                    next_r.cnt   = r.warm_set[WARM_W-1:0];
                    // restart the oscillator that ran the main clock
                    next_r.hi_en = ~r.low_held;
                    next_r.lo_en = r.low_held;
                    next_r.wlow  = r.low_held;
                end
            end
            SMER_WARM: begin
                // core held until the count runs out
                if (r.cnt == WARM_W'(0)) begin
                    next_r.st   = SMER_RUN;
                    next_r.run  = 1'b1;
                    next_r.tgc  = 1'b1;
                    next_r.pdrv = 1'b1;
                end else begin
                    next_r.cnt = r.cnt - WARM_W'(1);
                end
            end
            default: next_r.st = SMER_RUN;
        endcase
    end

    // ------------------------------------------------------------
    // state register; any reset ends stop and starts warm-up
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= SMER_RESET;
        end else if (clk_en) begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // outputs, straight from the record; bus handshake tied off
    // ------------------------------------------------------------
    assign hrdata        = r.rdata;
    assign hreadyout     = 1'b1;   // zero wait states
    assign hresp         = 1'b0;   // always okay
    assign high_osc_en   = r.hi_en;
    assign low_osc_en    = r.lo_en;
    assign core_run      = r.run;
    assign tg_clear      = r.tgc;
    assign port_drive    = r.pdrv;
    assign warm_from_low = r.wlow;
    assign pin_sync      = r.pin_s[1]; // feeds port and interrupt five
    assign resume_pc     = r.pc_q;
endmodule
